//--- src/sixadc_dev.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module sixadc_dev (
  input wire logic clk,
  input wire logic sys_rst,
  sixadc_if.dev link,
  input wire logic [sixadc_pkg::NCH-1:0][sixadc_pkg::WORD_BITS-1:0] sample_in,
  output logic [sixadc_pkg::NPAIR-1:0] span_used_q,
  output logic [sixadc_pkg::NPAIR-1:0] pairs_q,
  output logic conv_done
);
  localparam int SW = 24;
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  logic [2:0] stb_s;
  logic [2:0] lane_s;
  logic [2:0] chain_s;
  logic cs_s;
  logic sclk_s;
  logic wr_s;
  logic ce_s;
  logic sps_s;
  logic hs_s;
  logic span_s;
  logic [7:0] db_s;

  // Every pin is foreign to clk, so all of them pass the two-stage synchroniser.
  assign raw = {link.convert_start_strobe, link.cs_n, link.sclk, link.wr_n, link.lane_sel,
                link.chain_input, link.chain_enable, link.serial_parallel_select,
                link.hw_sw_select, link.span_pin, link.db_hi};
  sixadc_sync #(.W(SW)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(raw),
    .q(syn)
  );
  assign {stb_s, cs_s, sclk_s, wr_s, lane_s, chain_s, ce_s, sps_s, hs_s, span_s, db_s} = syn;

  logic [2:0] stb_prev_q;
  logic cs_prev_q;
  logic sclk_prev_q;
  logic wr_prev_q;
  // Strobe history resets high, yet a strobe tied high still fires once when the synchroniser first passes it after reset.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stb_prev_q <= 3'h7;
      // The synchroniser comes out of reset low, so these match it to avoid a false edge.
      cs_prev_q <= 1'b0;
      sclk_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end
    else
    begin
      stb_prev_q <= stb_s;
      cs_prev_q <= cs_s;
      sclk_prev_q <= sclk_s;
      wr_prev_q <= wr_s;
    end
  end

  logic [7:0] ctrl_q;
  logic busy_q;
  logic [sixadc_pkg::CNT_W-1:0] cnt_q;
  logic [2:0] stb_rise;
  logic [2:0] go_pairs;
  logic [2:0] span_hw_q;
  logic [2:0] span_eff;
  logic conv_go;
  logic conv_end;
  logic wr_rise;

  assign stb_rise = stb_s & ~stb_prev_q;
  assign conv_go = ~busy_q & (hs_s ? stb_rise[0] : |stb_rise); // [R5] [R6] [R22]
  assign go_pairs = hs_s ? ctrl_q[sixadc_pkg::CTRL_PAIR_POS +: 3] : stb_rise; // [R22]
  assign conv_end = busy_q && (cnt_q == '0); // [R5]
  assign span_eff = hs_s ? ctrl_q[sixadc_pkg::CTRL_SPAN_POS +: 3] : span_hw_q; // [R4] [R2]
  assign wr_rise = wr_s & ~wr_prev_q;
  assign conv_done = conv_end;
  assign link.busy = busy_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= sixadc_pkg::CTRL_RST;
    end
    else if (wr_rise && !cs_s)
    begin
      ctrl_q <= db_s; // [R23]
    end
  end

  // The span pin level stands for all three pairs; a set bit means the narrow span.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      span_hw_q <= 3'h0;
    end
    else if (conv_end)
    begin
      span_hw_q <= {3{span_s}}; // [R1] [R2] [R3]
    end
  end

  logic [sixadc_pkg::NCH-1:0][sixadc_pkg::WORD_BITS-1:0] hold_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      pairs_q <= 3'h0;
      span_used_q <= 3'h0;
      hold_q <= '0;
    end
    else if (conv_go)
    begin
      busy_q <= 1'b1; // [R5]
      cnt_q <= sixadc_pkg::CNT_W'(sixadc_pkg::CONV_CYC - 1);
      pairs_q <= go_pairs;
      span_used_q <= span_eff;
      hold_q <= sample_in;
    end
    else if (conv_end)
    begin
      busy_q <= 1'b0;
    end
    else if (busy_q)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  logic [sixadc_pkg::NCH-1:0][sixadc_pkg::WORD_BITS-1:0] res_q;
  logic [sixadc_pkg::NCH-1:0][sixadc_pkg::WORD_BITS-1:0] res_d;
  always_comb
  begin
    for (int i = 0; i < sixadc_pkg::NCH; i++)
    begin
      res_d[i] = pairs_q[i/2] ? (hold_q[i] & sixadc_pkg::RES_MASK) : '0; // [R12] [R14]
    end
  end

  logic new_q;
  logic load;
  logic cs_fall;
  logic frame_start;
  logic sclk_rise;
  logic sclk_fall;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      res_q <= '0;
      new_q <= 1'b0;
    end
    else
    begin
      if (conv_end)
      begin
        res_q <= res_d; // [R7]
      end
      // A result landing in the cycle of a frame start stays marked fresh.
      new_q <= conv_end | (new_q & ~load);
    end
  end

  // A frame only reloads the lanes once per conversion, so later frames of a
  // split read carry on from where the previous one stopped.
  assign cs_fall = cs_prev_q & ~cs_s;
  assign frame_start = cs_fall & wr_s & sps_s;
  assign load = frame_start & new_q; // [R8] [R11] [R20]
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_s;

  logic [2:0][sixadc_pkg::LANE_BITS-1:0] img;
  logic [6:0] ins;
  always_comb
  begin
    img = '0;
    if (lane_s[2])
    begin
      img[0] = {res_q[0], res_q[1], 64'h0};
      img[1] = {res_q[2], res_q[3], 64'h0};
      img[2] = {res_q[4], res_q[5], 64'h0};
    end
    else if (lane_s[1])
    begin
      img[0] = {res_q[0], res_q[1], res_q[4], 48'h0}; // [R10]
      img[1] = {res_q[2], res_q[3], res_q[5], 48'h0}; // [R10]
    end
    else
    begin
      img[0] = {res_q[0], res_q[1], res_q[2], res_q[3], res_q[4], res_q[5]}; // [R11]
    end
  end
  // Chained bits enter just below this lane's own words so they follow them directly.
  assign ins = lane_s[2] ? sixadc_pkg::INS_3LANE :
               (lane_s[1] ? sixadc_pkg::INS_2LANE : sixadc_pkg::INS_1LANE); // [R19] [R21]

  logic [2:0][sixadc_pkg::LANE_BITS-1:0] sh_q;
  logic [2:0] cbit_q;
  logic active_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sh_q <= '0;
    end
    else if (load)
    begin
      sh_q <= img; // [R13]
    end
    else if (sclk_rise)
    begin
      for (int l = 0; l < sixadc_pkg::NLANE; l++)
      begin
        sh_q[l] <= (sh_q[l] << 1) | (sixadc_pkg::sixadc_lane_t'(cbit_q[l]) << ins); // [R15] [R9]
      end
    end
  end

  // Downstream bits are valid on the falling edge and enter on the next rise.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cbit_q <= 3'h0;
    end
    else if (sclk_fall)
    begin
      cbit_q <= chain_s & {3{ce_s}}; // [R18] [R19] [R21] [R9]
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      active_q <= 1'b0;
    end
    else if (cs_s)
    begin
      active_q <= 1'b0;
    end
    else if (frame_start)
    begin
      active_q <= 1'b1; // [R13]
    end
  end

  assign link.dout = {sh_q[2][sixadc_pkg::LANE_BITS-1], sh_q[1][sixadc_pkg::LANE_BITS-1],
                      sh_q[0][sixadc_pkg::LANE_BITS-1]}; // [R14]
  assign link.dout_oe = {3{active_q}} & lane_s; // [R8] [R13]
endmodule // sixadc_dev

//--- src/sixadc_host.sv
`timescale 1ns/1ps
module sixadc_host (
  input wire logic clk,
  input wire logic sys_rst,
  sixadc_if.host link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata_q
);
  typedef enum {H_IDLE, H_STB, H_WR_LOW, H_WR_CS, H_WR_HIGH, H_CS_SETUP, H_SCK_LO, H_SCK_HI,
                H_CS_HOLD} sixadc_hstate_t;
  sixadc_hstate_t st_q, st_d;
  logic [7:0] tmr_q, tmr_d;
  logic [6:0] bits_q, bits_d;
  logic [2:0] stb_q, stb_d;
  logic cs_n_q, cs_n_d, sclk_q, sclk_d, wr_n_q, wr_n_d;
  logic [2:0][95:0] rx_q, rx_d;
  logic [31:0] cfg_q;
  logic [3:0] syn;
  logic busy_s;
  logic [2:0] dout_s;
  logic cmd_hit, cmd_conv, cmd_read, cmd_write, sample, tdone;

  sixadc_sync #(.W(4)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d({link.busy, link.dout_line}),
    .q(syn)
  );
  assign {busy_s, dout_s} = syn;

  assign cmd_hit = wr_stb && (addr == sixadc_pkg::ADDR_CMD) && (st_q == H_IDLE);
  assign cmd_conv = cmd_hit && wdata[sixadc_pkg::CMD_CONV];
  assign cmd_write = cmd_hit && wdata[sixadc_pkg::CMD_WRITE];
  assign cmd_read = cmd_hit && wdata[sixadc_pkg::CMD_READ] && !busy_s; // [R17]
  assign tdone = (tmr_q == 8'h00);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_q <= sixadc_pkg::CFG_RST;
    end
    else if (wr_stb && addr == sixadc_pkg::ADDR_CFG)
    begin
      cfg_q <= wdata;
    end
  end

  always_comb
  begin
    st_d = st_q;
    tmr_d = tdone ? tmr_q : tmr_q - 8'h01;
    bits_d = bits_q;
    stb_d = stb_q;
    cs_n_d = cs_n_q;
    sclk_d = sclk_q;
    wr_n_d = wr_n_q;
    sample = 1'b0;
    unique case (st_q)
      H_IDLE:
        if (cmd_conv)
        begin
          stb_d = cfg_q[sixadc_pkg::CFG_PAIRS +: 3];
          tmr_d = 8'(sixadc_pkg::STROBE_CYC - 1);
          st_d = H_STB;
        end
        else if (cmd_write)
        begin
          wr_n_d = 1'b0; // [R23]
          tmr_d = 8'(sixadc_pkg::WR_PHASE_CYC - 1);
          st_d = H_WR_LOW;
        end
        else if (cmd_read)
        begin
          cs_n_d = 1'b0;
          bits_d = 7'h00;
          tmr_d = 8'(sixadc_pkg::SCLK_HALF_CYC - 1);
          st_d = H_CS_SETUP;
        end
      H_STB:
        if (tdone)
        begin
          stb_d = 3'h0;
          st_d = H_IDLE;
        end
      H_WR_LOW:
        if (tdone)
        begin
          cs_n_d = 1'b0;
          tmr_d = 8'(sixadc_pkg::WR_PHASE_CYC - 1);
          st_d = H_WR_CS;
        end
      H_WR_CS:
        if (tdone)
        begin
          wr_n_d = 1'b1;
          tmr_d = 8'(sixadc_pkg::WR_PHASE_CYC - 1);
          st_d = H_WR_HIGH;
        end
      H_WR_HIGH, H_SCK_HI:
        if (tdone && (st_q == H_WR_HIGH || bits_q == cfg_q[sixadc_pkg::CFG_LEN +: 7]))
        begin
          cs_n_d = 1'b1;
          tmr_d = 8'(sixadc_pkg::SCLK_HALF_CYC - 1);
          st_d = H_CS_HOLD;
        end
        else if (tdone)
        begin
          sclk_d = 1'b0;
          sample = 1'b1;
          tmr_d = 8'(sixadc_pkg::SCLK_HALF_CYC - 1);
          st_d = H_SCK_LO;
        end
      H_CS_SETUP:
        if (tdone)
        begin
          sclk_d = 1'b0;
          sample = 1'b1; // [R15]
          tmr_d = 8'(sixadc_pkg::SCLK_HALF_CYC - 1);
          st_d = H_SCK_LO;
        end
      H_SCK_LO:
        if (tdone)
        begin
          sclk_d = 1'b1;
          bits_d = bits_q + 7'h01; // [R16]
          tmr_d = 8'(sixadc_pkg::SCLK_HALF_CYC - 1);
          st_d = H_SCK_HI;
        end
      H_CS_HOLD:
        if (tdone)
        begin
          st_d = H_IDLE;
        end
    endcase
  end

  // Each lane is taken on the falling edge the host itself drives.
  always_comb
  begin
    for (int l = 0; l < sixadc_pkg::NLANE; l++)
    begin
      rx_d[l] = sample ? {rx_q[l][94:0], dout_s[l]} : rx_q[l]; // [R15]
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= H_IDLE;
      tmr_q <= 8'h00;
      bits_q <= 7'h00;
      stb_q <= 3'h0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b1;
      wr_n_q <= 1'b1;
      rx_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      bits_q <= bits_d;
      stb_q <= stb_d;
      cs_n_q <= cs_n_d;
      sclk_q <= sclk_d;
      wr_n_q <= wr_n_d;
      rx_q <= rx_d;
    end
  end

  logic [287:0] rx_flat;
  logic [3:0] rx_sel;
  logic is_rx;
  logic [31:0] rx_word;
  logic [31:0] rmux;
  assign rx_flat = {rx_q[2], rx_q[1], rx_q[0]};
  assign rx_sel = addr[5:2] - sixadc_pkg::RX_FIRST;
  assign is_rx = (addr[7:6] == 2'h0) && (addr[1:0] == 2'h0) &&
                 (addr[5:2] >= sixadc_pkg::RX_FIRST) && (addr[5:2] <= sixadc_pkg::RX_LAST);
  assign rx_word = rx_flat[{rx_sel, 5'h00} +: 32];
  assign rmux = (addr == sixadc_pkg::ADDR_CFG) ? cfg_q :
                (addr == sixadc_pkg::ADDR_STAT) ? {30'h0000_0000, st_q != H_IDLE, busy_s} :
                is_rx ? rx_word : 32'h0000_0000;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      rdata_q <= rd_stb ? rmux : 32'h0000_0000;
    end
  end

  assign link.convert_start_strobe = stb_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.wr_n = wr_n_q;
  assign link.rd_n = 1'b0; // [R17]
  assign link.db_hi = cfg_q[sixadc_pkg::CFG_BYTE +: 8];
  assign link.lane_sel = cfg_q[sixadc_pkg::CFG_LANES +: 3]; // [R8]
  assign link.chain_enable = cfg_q[sixadc_pkg::CFG_CHAIN]; // [R20]
  assign link.hw_sw_select = cfg_q[sixadc_pkg::CFG_SW];
  assign link.span_pin = cfg_q[sixadc_pkg::CFG_SPAN];
  assign link.serial_parallel_select = cfg_q[sixadc_pkg::CFG_SERIAL];
endmodule // sixadc_host

//--- src/sixadc_if.sv
`timescale 1ns/1ps
interface sixadc_if;
  logic [2:0] convert_start_strobe;
  logic busy;
  logic cs_n;
  logic sclk;
  logic wr_n;
  logic rd_n;
  logic [7:0] db_hi;
  logic [2:0] lane_sel;
  logic chain_enable;
  logic [2:0] chain_input;
  logic serial_parallel_select;
  logic hw_sw_select;
  logic span_pin;
  logic [2:0] dout;
  logic [2:0] dout_oe;
  logic [2:0] dout_line;
  // An undriven lane reads low, as with a weak pull-down on the board.
  assign dout_line = dout & dout_oe;
  modport dev (
    input convert_start_strobe, cs_n, sclk, wr_n, db_hi, lane_sel, chain_enable,
    input chain_input, serial_parallel_select, hw_sw_select, span_pin,
    output busy, dout, dout_oe
  );
  modport host (
    output convert_start_strobe, cs_n, sclk, wr_n, rd_n, db_hi, lane_sel, chain_enable,
    output serial_parallel_select, hw_sw_select, span_pin,
    input busy, dout_line
  );
endinterface // sixadc_if

//--- src/sixadc_pkg.sv
// Overview of operation
// [R1] Hardware mode samples span pin at busy fall.
// [R2] Span pin high: two-times span, low: four-times.
// [R3] After reset span holds until first busy fall.
// [R4] Software mode: control bits set each pair's span.
// [R5] Strobe rise converts pairs; busy high 3 us.
// [R6] Strobe rises ignored while busy is high.
// [R7] Conversion end loads results into output register.
// [R8] Lane enables pick lanes; 32 or 16-clock frames.
// [R9] Zeros shift out after all valid results.
// [R10] Two lanes: A gets 1,2,5; B gets 3,4,6.
// [R11] One lane: 96, 3x32 or 6x16 clock frames.
// [R12] Unconverted pairs still occupy all-zero result slots.
// [R13] Chip select fall drives lanes with first MSB.
// [R14] Sixteen-bit words, MSB first, short results zero-led.
// [R15] MSB valid first fall; rest launched on rises.
// [R16] Host gives sixteen clocks per result read.
// [R17] Host reads after busy falls, read strobe low.
// [R18] Chain enable makes chain inputs feed lanes A-C.
// [R19] Two-lane chain: own 48 bits, then forwarded 48.
// [R20] Chain read may be six 16-clock frames.
// [R21] Three-lane chain: own 32 bits, then forwarded 32.
// [R22] Software mode pair bits choose pairs, ascending order.
// [R23] Control byte latched on write rise, reset zero.
package sixadc_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CONV_TIME_NS = 3000;
  localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = $clog2(CONV_CYC);
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS * CLK_MHZ) / 2000;
  localparam int STROBE_CYC = 8;
  localparam int WR_PHASE_CYC = 4;
  localparam int NCH = 6;
  localparam int NPAIR = 3;
  localparam int NLANE = 3;
  localparam int WORD_BITS = 16;
  localparam int RES_BITS = 16;
  localparam logic [15:0] RES_MASK = 16'((32'h0000_0001 << RES_BITS) - 1);
  localparam int LANE_BITS = 96;
  typedef logic [LANE_BITS-1:0] sixadc_lane_t;
  localparam logic [6:0] INS_3LANE = 7'h40;
  localparam logic [6:0] INS_2LANE = 7'h30;
  localparam logic [6:0] INS_1LANE = 7'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_PAIR_POS = 5;
  localparam int CTRL_SPAN_POS = 2;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [3:0] RX_FIRST = 4'h4;
  localparam logic [3:0] RX_LAST = 4'hC;
  localparam int CMD_CONV = 0;
  localparam int CMD_READ = 1;
  localparam int CMD_WRITE = 2;
  localparam int CFG_PAIRS = 0;
  localparam int CFG_LANES = 3;
  localparam int CFG_CHAIN = 6;
  localparam int CFG_SW = 7;
  localparam int CFG_SPAN = 8;
  localparam int CFG_SERIAL = 9;
  localparam int CFG_BYTE = 16;
  localparam int CFG_LEN = 24;
  localparam logic [31:0] CFG_RST = 32'h2000_0239;
endpackage

//--- src/sixadc_sync.sv
`timescale 1ns/1ps
module sixadc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // sixadc_sync

//--- tb/sixadc_monitor.sv
`timescale 1ns/1ps
module sixadc_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] convert_start_strobe,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic wr_n,
  input wire logic serial_parallel_select,
  input wire logic hw_sw_select,
  input wire logic [2:0] lane_sel,
  input wire logic [2:0] dout,
  input wire logic [2:0] dout_oe
);
  // A counter is used because the conversion is far longer than a repetition may span.
  logic [10:0] busy_len_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_len_q <= 11'h000;
    else
      busy_len_q <= busy ? busy_len_q + 11'h001 : 11'h000;
  end
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_busy_length: assert property ($fell(busy) |-> busy_len_q == 11'(sixadc_pkg::CONV_CYC))
    else $error("busy high for the wrong number of cycles");
  a_busy_cause: assert property ($rose(busy) |-> $past(convert_start_strobe, 2) != 3'h0)
    else $error("busy rose without a start strobe");
  a_busy_start: assert property (!hw_sw_select && !busy && $rose(|convert_start_strobe)
    |-> ##[2:6] busy) else $error("start strobe did not raise busy");
  a_oe_on_frame: assert property ($fell(cs_n) && wr_n && serial_parallel_select
    |-> ##[2:6] ((dout_oe & lane_sel) == lane_sel)) else $error("lanes not driven in frame");
  a_lane_off: assert property ((dout_oe & ~lane_sel) == 3'h0)
    else $error("disabled lane driven");
  a_oe_idle: assert property (cs_n [*8] |-> dout_oe == 3'h0)
    else $error("lanes driven outside a frame");
  a_bit_held: assert property (!cs_n && $fell(sclk) |-> $stable(dout) [*3])
    else $error("lane bit moved at the sampling edge");
  a_par_quiet: assert property (!serial_parallel_select |-> dout_oe == 3'h0)
    else $error("lanes driven in parallel mode");
  a_write_quiet: assert property (!wr_n |-> dout_oe == 3'h0)
    else $error("lanes driven during control write");
endmodule // sixadc_monitor

//--- tb/sixadc_test.sv
`timescale 1ns/1ps
module sixadc_test;
  logic clk;
  logic sys_rst;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [31:0] rdata_q;
  logic [5:0][15:0] sample_in;
  logic [5:0][15:0] snap;
  logic [2:0] span_used_q;
  logic [2:0] pairs_q;
  logic conv_done;
  logic sclk_q;
  logic [2:0] c_pairs, c_lanes, p_snap, sp_snap, m_span;
  logic c_chain, c_sw, c_span, c_ser;
  logic [7:0] c_ctrl;
  logic [6:0] c_len;
  logic [95:0] m_rx [3];
  logic [95:0] m_str [3];
  logic [95:0] ch_sh [3];
  logic [15:0] v [6];
  logic [31:0] got;
  integer seed;
  int miscompares = 0;
  int cmp_count = 0;
  int n_conv = 0;
  int n_done = 0;
  sixadc_if link ();
  sixadc_host u_sixadc_host (.clk(clk), .sys_rst(sys_rst), .link(link), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q));
  sixadc_dev u_sixadc_dev (.clk(clk), .sys_rst(sys_rst), .link(link), .sample_in(sample_in),
    .span_used_q(span_used_q), .pairs_q(pairs_q), .conv_done(conv_done));
  sixadc_monitor u_sixadc_monitor (.clk(clk), .sys_rst(sys_rst),
    .convert_start_strobe(link.convert_start_strobe), .busy(link.busy), .cs_n(link.cs_n),
    .sclk(link.sclk), .wr_n(link.wr_n), .serial_parallel_select(link.serial_parallel_select),
    .hw_sw_select(link.hw_sw_select), .lane_sel(link.lane_sel), .dout(link.dout),
    .dout_oe(link.dout_oe));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The downstream device launches a fresh chain bit after each link clock rise.
  always @(posedge clk)
  begin
    sclk_q <= link.sclk;
    if (!sclk_q && link.sclk)
      link.chain_input <= 3'($random(seed));
  end
  always @(negedge link.sclk)
  begin
    if (!link.cs_n)
      for (int l = 0; l < 3; l++)
        ch_sh[l] <= {ch_sh[l][94:0], link.chain_input[l]};
  end
  always @(posedge clk)
  begin
    if (conv_done === 1'b1)
      n_done <= n_done + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata_q;
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wait_idle;
    int i;
    repeat (16) @(posedge clk);
    for (i = 0; i < 5000; i++)
    begin
      rd(sixadc_pkg::ADDR_STAT, got);
      if (got[1:0] === 2'h0)
        break;
    end
    if (i == 5000)
    begin
      miscompares++;
      $display("FAIL %0t wait limit reached", $time);
      end_of_test();
    end
  endtask
  task apply_cfg;
    wr(sixadc_pkg::ADDR_CFG, {1'b0, c_len, c_ctrl, 6'h00, c_ser, c_span, c_sw, c_chain, c_lanes,
      c_pairs});
  endtask
  task conv_start;
    @(posedge clk);
    for (int c = 0; c < 6; c++)
      sample_in[c] <= 16'($random(seed));
    apply_cfg();
    snap = sample_in;
    p_snap = c_sw ? c_ctrl[7:5] : c_pairs;
    sp_snap = c_sw ? c_ctrl[4:2] : m_span;
    wr(sixadc_pkg::ADDR_CMD, 32'h0000_0001);
  endtask
  task conv_end;
    wait_idle();
    chk(32'(pairs_q), 32'(p_snap), "pairs");
    chk(32'(span_used_q), 32'(sp_snap), "span");
    if (!c_sw)
      m_span = {3{c_span}};
    n_conv++;
    for (int c = 0; c < 6; c++)
      v[c] = p_snap[c / 2] ? snap[c] : 16'h0000;
    m_str[1] = '0;
    m_str[2] = '0;
    if (c_lanes == 3'h7)
    begin
      m_str[0] = {v[0], v[1], 64'h0};
      m_str[1] = {v[2], v[3], 64'h0};
      m_str[2] = {v[4], v[5], 64'h0};
    end
    else if (c_lanes == 3'h3)
    begin
      m_str[0] = {v[0], v[1], v[4], 48'h0};
      m_str[1] = {v[2], v[3], v[5], 48'h0};
    end
    else
      m_str[0] = {v[0], v[1], v[2], v[3], v[4], v[5]};
  endtask
  task frame(input int len);
    c_len = len[6:0];
    apply_cfg();
    wr(sixadc_pkg::ADDR_CMD, 32'h0000_0002);
    wait_idle();
    for (int l = 0; l < 3; l++)
    begin
      if (!c_ser)
        m_str[l] = '0;
      m_rx[l] = (m_rx[l] << len) | (m_str[l] >> (96 - len));
      m_str[l] = m_str[l] << len;
      // Chained bits fill the second half of the frame, oldest first.
      if (c_chain && c_lanes[l])
        m_rx[l] = m_rx[l] | ((ch_sh[l] << (96 - len)) >> (96 - len / 2));
    end
    for (int k = 0; k < 9; k++)
    begin
      rd(8'h10 + 8'(4 * k), got);
      chk(got, 32'({m_rx[2], m_rx[1], m_rx[0]} >> (32 * k)), "rx word");
    end
  endtask
  initial
  begin
    seed = 84951;
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    sample_in = '0;
    link.chain_input = 3'h0;
    sclk_q = 1'b1;
    {c_pairs, c_lanes, m_span} = 9'h1F8;
    {c_chain, c_sw, c_span, c_ser, c_ctrl, c_len} = {4'h1, 8'h00, 7'h20};
    for (int l = 0; l < 3; l++)
      {m_rx[l], m_str[l]} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(sixadc_pkg::ADDR_CFG, got);
    chk(got, sixadc_pkg::CFG_RST, "cfg reset");
    rd(8'h3C, got);
    chk(got, 32'h0000_0000, "unmapped");
    c_span = 1'b1;
    conv_start();
    conv_end();
    frame(32);
    $display("test reset done");
    for (int k = 1; k < 8; k++)
    begin
      c_pairs = k[2:0];
      c_lanes = (k % 3 == 0) ? 3'h7 : ((k % 3 == 1) ? 3'h3 : 3'h1);
      c_span = k[0];
      conv_start();
      conv_end();
      frame((c_lanes == 3'h7) ? 32 : ((c_lanes == 3'h3) ? 48 : 96));
    end
    $display("test hardware pairs done");
    {c_pairs, c_lanes} = 6'h39;
    conv_start();
    conv_end();
    repeat (3) frame(32);
    c_lanes = 3'h7;
    conv_start();
    conv_end();
    frame(16);
    frame(16);
    frame(24);
    {c_pairs, c_lanes} = 6'h11;
    conv_start();
    conv_end();
    frame(64);
    $display("test split frames done");
    {c_pairs, c_lanes} = 6'h3F;
    conv_start();
    repeat (40) @(posedge clk);
    sample_in <= ~sample_in;
    c_pairs = 3'h1;
    apply_cfg();
    wr(sixadc_pkg::ADDR_CMD, 32'h0000_0001);
    conv_end();
    frame(32);
    c_ser = 1'b0;
    frame(32);
    {c_ser, c_chain, c_pairs} = 5'h1F;
    conv_start();
    conv_end();
    frame(64);
    c_lanes = 3'h3;
    conv_start();
    conv_end();
    frame(96);
    c_chain = 1'b0;
    $display("test busy, parallel and chain done");
    {c_sw, c_pairs} = 4'h9;
    for (int k = 1; k < 8; k++)
    begin
      c_ctrl = {k[2:0], 3'($random(seed)), 2'h0};
      apply_cfg();
      wr(sixadc_pkg::ADDR_CMD, 32'h0000_0004);
      wait_idle();
      conv_start();
      conv_end();
      frame(32);
    end
    $display("test software mode done");
    chk(32'(n_done), 32'(n_conv), "done pulses");
    end_of_test();
  end
endmodule // sixadc_test
